/* File: tpmch_pkg.sv */
// tpmch_pkg: constants and types for the timer channel mode/value block.
// assumes a byte-wide register port and a 16-bit counter supplied from outside.
package tpmch_pkg;
	// register indexes on the plain register port
	localparam logic [1:0] TPMCH_ADDR_SC = 2'h0;
	localparam logic [1:0] TPMCH_ADDR_VH = 2'h1;
	localparam logic [1:0] TPMCH_ADDR_VL = 2'h2;
	localparam int         TPMCH_AW      = 2;
	// control register fields
	localparam int TPMCH_FLAG_BIT = 7;
	localparam int TPMCH_IE_BIT   = 6;
	localparam int TPMCH_MSB_BIT  = 5;
	localparam int TPMCH_MSA_BIT  = 4;
	localparam int TPMCH_ELSB_BIT = 3;
	localparam int TPMCH_ELSA_BIT = 2;
	// reset values
	localparam logic [7:0]  TPMCH_SC_RST  = 8'h00;
	localparam logic [15:0] TPMCH_VAL_RST = 16'h0000;
	// edge/level encodings
	localparam logic [1:0] TPMCH_EL_OFF    = 2'h0;
	localparam logic [1:0] TPMCH_EL_RISE   = 2'h1;
	localparam logic [1:0] TPMCH_EL_FALL   = 2'h2;
	localparam logic [1:0] TPMCH_EL_BOTH   = 2'h3;
	localparam logic [1:0] TPMCH_EL_TOGGLE = 2'h1;
	localparam logic [1:0] TPMCH_EL_CLEAR  = 2'h2;
	localparam logic [1:0] TPMCH_EL_SET    = 2'h3;
	typedef enum logic [2:0] {
		TPMCH_MODE_OFF,
		TPMCH_MODE_IC,
		TPMCH_MODE_OC,
		TPMCH_MODE_EPWM,
		TPMCH_MODE_CPWM
	} tpmch_mode_e;
endpackage

/* File: tpmch_cfg_if.sv */
// tpmch_cfg_if: decoded channel configuration passed from the register file
// to the pin logic; both ends run on the same clock.
interface tpmch_cfg_if;
	import tpmch_pkg::*;
	tpmch_mode_e mode;
	logic [1:0]  edge_level;
	logic [15:0] compare_val;
	logic        cap_event;
	logic        match_event;
	modport regs (output mode, output edge_level, output compare_val,
		input cap_event, input match_event);
	modport pin  (input mode, input edge_level, input compare_val,
		output cap_event, output match_event);
endinterface

/* File: tpmch_pin.sv */
// tpmch_pin: pin synchroniser, capture edge detection, compare match and
// pin drive for one channel. assumes count_tick pulses once per timer count.
module tpmch_pin
	import tpmch_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// counter
	input  wire logic        count_tick,
	input  wire logic [15:0] counter_val,
	input  wire logic        count_down,
	input  wire logic        counter_wrap,
	// configuration
	tpmch_cfg_if.pin         cfg,
	// pin
	input  wire logic        pin_in,
	output logic             pin_out,
	output logic             pin_oe
);
	logic [2:0] sync_reg;
	logic       level_reg;
	logic       pin_out_reg;
	logic       pin_out_next;

	// third stage agreeing with second marks a settled level
	wire settled  = sync_reg[1] == sync_reg[2];
	wire rise     = settled && sync_reg[2] && !level_reg;
	wire fall     = settled && !sync_reg[2] && level_reg;
	wire cap_hit  = (cfg.mode == TPMCH_MODE_IC) &&
		((cfg.edge_level == TPMCH_EL_RISE && rise) ||
		 (cfg.edge_level == TPMCH_EL_FALL && fall) ||
		 (cfg.edge_level == TPMCH_EL_BOTH && (rise || fall)));
	wire match    = count_tick && (counter_val == cfg.compare_val);
	wire cmp_mode = (cfg.mode == TPMCH_MODE_OC) || (cfg.mode == TPMCH_MODE_EPWM) ||
		(cfg.mode == TPMCH_MODE_CPWM);
	wire low_true = cfg.edge_level[0];

	assign cfg.cap_event   = cap_hit;
	assign cfg.match_event = match && cmp_mode;
	assign pin_oe  = cmp_mode && (cfg.edge_level != TPMCH_EL_OFF);
	assign pin_out = pin_out_reg;

	always_comb begin
		pin_out_next = pin_out_reg;
		case (cfg.mode)
			TPMCH_MODE_OC: begin
				if (match) begin
					case (cfg.edge_level)
						TPMCH_EL_TOGGLE: pin_out_next = !pin_out_reg;
						TPMCH_EL_CLEAR:  pin_out_next = 1'b0;
						TPMCH_EL_SET:    pin_out_next = 1'b1;
						default:         pin_out_next = pin_out_reg;
					endcase
				end
			end
			TPMCH_MODE_EPWM: begin
				if (match)
					pin_out_next = low_true;
				else if (count_tick && counter_wrap)
					pin_out_next = !low_true;
			end
			TPMCH_MODE_CPWM: begin
				if (match && !count_down)
					pin_out_next = low_true;
				else if (match && count_down)
					pin_out_next = !low_true;
			end
			default: pin_out_next = pin_out_reg;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_reg    <= 3'h0;
			level_reg   <= 1'b0;
			pin_out_reg <= 1'b0;
		end else begin
			sync_reg    <= {sync_reg[1:0], pin_in};
			if (settled)
				level_reg <= sync_reg[2];
			pin_out_reg <= pin_out_next;
		end
	end
endmodule

/* File: tpmch_top.sv */
// tpmch_top: one timer channel: status/control register, coherent 16-bit
// value buffering, mode decode and the pin logic.
// assumes the counter, prescaler and modulo logic live outside and present
// the count, a tick per count, direction and the center-aligned select.
module tpmch_top
	import tpmch_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// register port
	input  wire logic [TPMCH_AW-1:0] reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// counter side
	input  wire logic                count_tick,
	input  wire logic [15:0]         counter_val,
	input  wire logic                count_down,
	input  wire logic                counter_wrap,
	input  wire logic                center_aligned_select,
	// channel pin
	input  wire logic                chan_pin_in,
	output logic                     chan_pin_out,
	output logic                     chan_pin_oe,
	// interrupt request
	output logic                     chan_irq
);
	tpmch_cfg_if cfg_bus ();

	logic        chan_event_flag_reg;
	logic        chan_irq_enable_reg;
	logic        mode_select_high_reg;
	logic        mode_select_low_reg;
	logic [1:0]  edge_level_reg;
	logic [15:0] value_reg;
	logic [15:0] rd_buf_reg;
	logic        rd_frozen_reg;
	logic        rd_first_hi_reg;
	logic [7:0]  wr_hi_reg;
	logic [7:0]  wr_lo_reg;
	logic        wr_hi_seen_reg;
	logic        wr_lo_seen_reg;
	logic        flag_armed_reg;
	logic [7:0]  rdata_reg;

	// access decode
	wire wr_sc = reg_wr && (reg_addr == TPMCH_ADDR_SC);
	wire wr_vh = reg_wr && (reg_addr == TPMCH_ADDR_VH);
	wire wr_vl = reg_wr && (reg_addr == TPMCH_ADDR_VL);
	wire rd_sc = reg_rd && (reg_addr == TPMCH_ADDR_SC);
	wire rd_vh = reg_rd && (reg_addr == TPMCH_ADDR_VH);
	wire rd_vl = reg_rd && (reg_addr == TPMCH_ADDR_VL);

	// mode decode from the select bits
	function automatic tpmch_mode_e decode_mode(input logic cas, input logic msb,
		input logic msa, input logic [1:0] el);
		if (el == TPMCH_EL_OFF && !(msa && !msb && !cas))
			decode_mode = TPMCH_MODE_OFF;
		else if (cas)
			decode_mode = TPMCH_MODE_CPWM;
		else if (msb)
			decode_mode = TPMCH_MODE_EPWM;
		else if (msa)
			decode_mode = TPMCH_MODE_OC;
		else
			decode_mode = TPMCH_MODE_IC;
	endfunction

	// center select applies to every channel
	wire tpmch_mode_e mode = decode_mode(center_aligned_select, mode_select_high_reg,
		mode_select_low_reg, edge_level_reg);
	wire is_capture = (mode == TPMCH_MODE_IC);

	assign cfg_bus.mode        = mode;
	assign cfg_bus.edge_level  = edge_level_reg;
	assign cfg_bus.compare_val = value_reg;

	wire event_hit = cfg_bus.cap_event || cfg_bus.match_event;
	// clear needs a prior read with the flag set and no event since
	wire flag_clear = wr_sc && !reg_wdata[TPMCH_FLAG_BIT] && flag_armed_reg;

	wire [15:0] rd_view  = rd_frozen_reg ? rd_buf_reg : value_reg;
	wire [7:0]  sc_view  = {chan_event_flag_reg, chan_irq_enable_reg, mode_select_high_reg,
		mode_select_low_reg, edge_level_reg, 2'h0};
	wire [7:0]  rd_mux   = rd_sc ? sc_view :
		rd_vh ? rd_view[15:8] :
		rd_vl ? rd_view[7:0] : 8'h00;

	// pair complete on the second byte
	wire pair_done = !is_capture && ((wr_vh && wr_lo_seen_reg) || (wr_vl && wr_hi_seen_reg));
	wire [15:0] pair_val = {wr_vh ? reg_wdata : wr_hi_reg, wr_vl ? reg_wdata : wr_lo_reg};

	assign chan_irq  = chan_event_flag_reg && chan_irq_enable_reg;
	assign reg_rdata = rdata_reg;

	// control register and flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_event_flag_reg  <= TPMCH_SC_RST[TPMCH_FLAG_BIT];
			chan_irq_enable_reg  <= TPMCH_SC_RST[TPMCH_IE_BIT];
			mode_select_high_reg <= TPMCH_SC_RST[TPMCH_MSB_BIT];
			mode_select_low_reg  <= TPMCH_SC_RST[TPMCH_MSA_BIT];
			edge_level_reg       <= TPMCH_SC_RST[TPMCH_ELSB_BIT:TPMCH_ELSA_BIT];
			flag_armed_reg       <= 1'b0;
		end else begin
			if (wr_sc) begin
				chan_irq_enable_reg  <= reg_wdata[TPMCH_IE_BIT];
				mode_select_high_reg <= reg_wdata[TPMCH_MSB_BIT];
				mode_select_low_reg  <= reg_wdata[TPMCH_MSA_BIT];
				edge_level_reg       <= reg_wdata[TPMCH_ELSB_BIT:TPMCH_ELSA_BIT];
			end
			if (event_hit)
				chan_event_flag_reg <= 1'b1;
			else if (flag_clear)
				chan_event_flag_reg <= 1'b0;
			// a new event restarts the clearing sequence
			if (event_hit || wr_sc)
				flag_armed_reg <= 1'b0;
			else if (rd_sc && chan_event_flag_reg)
				flag_armed_reg <= 1'b1;
		end
	end

	// value register, read freeze and write pairing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			value_reg       <= TPMCH_VAL_RST;
			rd_buf_reg      <= TPMCH_VAL_RST;
			rd_frozen_reg   <= 1'b0;
			rd_first_hi_reg <= 1'b0;
			wr_hi_reg       <= 8'h00;
			wr_lo_reg       <= 8'h00;
			wr_hi_seen_reg  <= 1'b0;
			wr_lo_seen_reg  <= 1'b0;
			rdata_reg       <= 8'h00;
		end else begin
			rdata_reg <= rd_mux;
			if (cfg_bus.cap_event)
				value_reg <= counter_val;
			else if (is_capture && wr_vh)
				value_reg <= {reg_wdata, value_reg[7:0]};
			else if (is_capture && wr_vl)
				value_reg <= {value_reg[15:8], reg_wdata};
			else if (pair_done)
				value_reg <= pair_val;
			if (wr_sc)
				rd_frozen_reg <= 1'b0;
			else if (is_capture && (rd_vh || rd_vl)) begin
				if (!rd_frozen_reg) begin
					rd_frozen_reg   <= 1'b1;
					rd_buf_reg      <= value_reg;
					rd_first_hi_reg <= rd_vh;
				end else if (rd_vh != rd_first_hi_reg)
					rd_frozen_reg <= 1'b0;
			end
			if (wr_sc || pair_done || is_capture) begin
				wr_hi_seen_reg <= 1'b0;
				wr_lo_seen_reg <= 1'b0;
			end else begin
				if (wr_vh) begin
					wr_hi_reg      <= reg_wdata;
					wr_hi_seen_reg <= 1'b1;
				end
				if (wr_vl) begin
					wr_lo_reg      <= reg_wdata;
					wr_lo_seen_reg <= 1'b1;
				end
			end
		end
	end

	tpmch_pin u_pin (
		.clk          (clk),
		.reset_n      (reset_n),
		.count_tick   (count_tick),
		.counter_val  (counter_val),
		.count_down   (count_down),
		.counter_wrap (counter_wrap),
		.cfg          (cfg_bus.pin),
		.pin_in       (chan_pin_in),
		.pin_out      (chan_pin_out),
		.pin_oe       (chan_pin_oe)
	);
endmodule

/* File: tpmch_sva.sv */
// tpmch_sva: port assertions for one timer channel.
// assumes only the top ports; control bits are shadowed from register writes.
module tpmch_sva
	import tpmch_pkg::*;
(
	// clock and reset
	input wire logic                clk,
	input wire logic                reset_n,
	// register port
	input wire logic [TPMCH_AW-1:0] reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	// channel
	input wire logic                center_aligned_select,
	input wire logic                chan_pin_oe,
	input wire logic                chan_irq
);
	logic [4:0] cfg_reg;
	wire        ctl_wr = reg_wr && reg_addr == TPMCH_ADDR_SC;
	wire        ctl_rd = reg_rd && reg_addr == TPMCH_ADDR_SC;
	// enable, mode and edge/level bits as software last wrote them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cfg_reg <= 5'h00;
		else if (ctl_wr)
			cfg_reg <= reg_wdata[6:2];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_ie_blocks_irq: assert property (!cfg_reg[4] |-> !chan_irq)
		else $error("irq with enable clear");
	a_irq_masked_write: assert property (ctl_wr && !reg_wdata[6] |=> !chan_irq)
		else $error("irq after enable cleared");
	a_irq_shows_flag: assert property (ctl_rd && chan_irq |=> reg_rdata[7])
		else $error("irq without flag");
	a_ctrl_readback: assert property (ctl_rd |=> reg_rdata[6:0] == {$past(cfg_reg), 2'h0})
		else $error("control readback wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_pin_released: assert property (cfg_reg[1:0] == 2'h0 |-> !chan_pin_oe)
		else $error("pin driven with edge/level zero");
	a_capture_no_drive: assert property (!center_aligned_select && cfg_reg[3:2] == 2'h0
		|-> !chan_pin_oe)
		else $error("pin driven in capture");
	a_output_drive: assert property ((center_aligned_select || cfg_reg[3:2] != 2'h0)
		&& cfg_reg[1:0] != 2'h0 |-> chan_pin_oe)
		else $error("pin not driven in output mode");
endmodule
bind tpmch_top tpmch_sva i_tpmch_sva (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .center_aligned_select, .chan_pin_oe, .chan_irq);

/* File: tpmch_pin_src.sv */
// tpmch_pin_src: external signal source on the channel pin.
// assumes the bench names the level; the pin moves only after a clock edge.
module tpmch_pin_src (
	// clock
	input  wire logic clk,
	// command
	input  wire logic level,
	// pin
	output logic      pin
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(posedge clk)
		pin <= level;
endmodule

/* File: tpmch_top_tb.sv */
// tpmch_top_tb: self-checking bench for one timer channel.
// assumes the bench plays counter and software; tpmch_pin_src drives the pin.
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tpmch_top_tb
	import tpmch_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic                count_tick = 1'b0, count_down = 1'b0, counter_wrap = 1'b0;
	logic                center_aligned_select = 1'b0, pin_level = 1'b0;
	logic [TPMCH_AW-1:0] reg_addr = 2'h0;
	logic [7:0]          reg_wdata = 8'h00, reg_rdata, d;
	logic [15:0]         counter_val = 16'h0000;
	logic                chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq;
	int                  fails = 0, n_compared = 0;
	tpmch_top i_tpmch_top (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.count_tick, .counter_val, .count_down, .counter_wrap, .center_aligned_select,
		.chan_pin_in, .chan_pin_out, .chan_pin_oe, .chan_irq);
	tpmch_pin_src i_tpmch_pin_src (.clk, .level(pin_level), .pin(chan_pin_in));
	initial forever #2.5 clk = ~clk;
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// let the write settle before the caller looks at outputs
		#1;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic tick(input logic [15:0] v, input logic w, input logic dn);
		@(posedge clk);
		counter_val <= v;
		counter_wrap <= w;
		count_down <= dn;
		count_tick <= 1'b1;
		@(posedge clk);
		count_tick <= 1'b0;
		counter_wrap <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic pin_to(input logic l);
		@(posedge clk);
		pin_level <= l;
		repeat (8) @(posedge clk);
	endtask
	task automatic cap(input logic [15:0] v);
		@(posedge clk);
		counter_val <= v;
		pin_to(~pin_level);
	endtask
	task automatic t_reset_vals();
		rd(TPMCH_ADDR_VH, d);
		`CHK("value_high", 8'h00, d)
		rd(TPMCH_ADDR_VL, d);
		`CHK("value_low", 8'h00, d)
		rd(2'h3, d);
		`CHK("unmapped", 8'h00, d)
	endtask
	task automatic t_compare();
		wr(TPMCH_ADDR_SC, 8'h5C);
		wr(TPMCH_ADDR_VH, 8'h56);
		wr(TPMCH_ADDR_SC, 8'h5C);
		wr(TPMCH_ADDR_VL, 8'h34);
		wr(TPMCH_ADDR_VH, 8'h12);
		tick(16'h5634, 1'b0, 1'b0);
		`CHK("irq_nomatch", 1'b0, chan_irq)
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("pin_set", 1'b1, chan_pin_out)
		`CHK("irq_match", 1'b1, chan_irq)
		wr(TPMCH_ADDR_SC, 8'h5C);
		`CHK("irq_noread", 1'b1, chan_irq)
		rd(TPMCH_ADDR_SC, d);
		`CHK("control", 8'hDC, d)
		wr(TPMCH_ADDR_SC, 8'h5C);
		`CHK("irq_cleared", 1'b0, chan_irq)
	endtask
	task automatic t_oc_actions();
		logic [1:0] els [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
		logic       pins [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			wr(TPMCH_ADDR_SC, {4'h1, els[i], 2'h0});
			tick(16'h1234, 1'b0, 1'b0);
			`CHK("oc_pin", pins[i], chan_pin_out)
		end
		`CHK("irq_disabled", 1'b0, chan_irq)
		rd(TPMCH_ADDR_SC, d);
		wr(TPMCH_ADDR_SC, 8'h10);
		wr(TPMCH_ADDR_SC, 8'h90);
		wr(TPMCH_ADDR_SC, 8'h50);
		`CHK("flag_write_one", 1'b0, chan_irq)
		`CHK("oe_released", 1'b0, chan_pin_oe)
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("soft_compare", 1'b1, chan_irq)
	endtask
	task automatic t_pwm();
		wr(TPMCH_ADDR_SC, 8'h28);
		tick(16'hFFFF, 1'b1, 1'b0);
		`CHK("epwm_wrap_hi", 1'b1, chan_pin_out)
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("epwm_match_hi", 1'b0, chan_pin_out)
		wr(TPMCH_ADDR_SC, 8'h24);
		tick(16'hFFFF, 1'b1, 1'b0);
		`CHK("epwm_wrap_lo", 1'b0, chan_pin_out)
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("epwm_match_lo", 1'b1, chan_pin_out)
		@(posedge clk);
		center_aligned_select <= 1'b1;
		wr(TPMCH_ADDR_SC, 8'h18);
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("cpwm_up_hi", 1'b0, chan_pin_out)
		tick(16'h1234, 1'b0, 1'b1);
		`CHK("cpwm_down_hi", 1'b1, chan_pin_out)
		wr(TPMCH_ADDR_SC, 8'h04);
		`CHK("cpwm_oe", 1'b1, chan_pin_oe)
		tick(16'h1234, 1'b0, 1'b1);
		tick(16'h1234, 1'b0, 1'b0);
		`CHK("cpwm_up_lo", 1'b1, chan_pin_out)
		@(posedge clk);
		center_aligned_select <= 1'b0;
	endtask
	task automatic t_capture();
		for (int e = 1; e < 4; e++) begin
			rd(TPMCH_ADDR_SC, d);
			wr(TPMCH_ADDR_SC, {4'h0, e[1:0], 2'h0});
			pin_to(1'b1);
			rd(TPMCH_ADDR_SC, d);
			`CHK("flag_rise", e[0], d[7])
			wr(TPMCH_ADDR_SC, {4'h0, e[1:0], 2'h0});
			pin_to(1'b0);
			rd(TPMCH_ADDR_SC, d);
			`CHK("flag_fall", e[1], d[7])
		end
		cap(16'hA5C3);
		rd(TPMCH_ADDR_VH, d);
		`CHK("cap_high", 8'hA5, d)
		cap(16'h1E2F);
		rd(TPMCH_ADDR_VL, d);
		`CHK("frozen_low", 8'hC3, d)
		rd(TPMCH_ADDR_VH, d);
		`CHK("live_high", 8'h1E, d)
		wr(TPMCH_ADDR_SC, 8'h0C);
		cap(16'h3C4D);
		rd(TPMCH_ADDR_VL, d);
		`CHK("released_low", 8'h4D, d)
	endtask
	task automatic end_of_test();
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#50000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset_vals();
		t_compare();
		t_oc_actions();
		t_pwm();
		t_capture();
		end_of_test();
	end
endmodule
